//--- hw/monitor_performance_counters.sv
// Function
// - stop a monitor's counts when a code disabling it is stored.
// - resume that monitor's counts once the disabling code clears.
// - stop a monitor's counts while auxiliary drive operation disables it.
// - resume suspended counts when auxiliary drive operation ends.
// - freeze all monitor counts on a criteria-input pending fault.
// - restart all monitor counts once the criteria-input fault clears.
// - report numerator and denominator for each of seven components.
// - also report a general denominator and an ignition cycle counter.
// - track monitors separately, report the pair with the lowest ratio.
// - on equal ratios report the monitor with the largest denominator.
// - ratio is numerator over denominator, compared by cross products.
// - ignition counter steps by one, at most once per driving cycle.
// - step ignition counter after two seconds of engine running.
// - block ignition counter on an engine speed fault.
// - nothing else blocks ignition counter; resume when fault clears.
// - general denominator steps by one, at most once per driving cycle.
// - step general denominator once base criteria are met in a cycle.
// - base: 600 s run, 300 s at speed, 30 s idle, low, warm.
// - block general denominator on a criteria-input pending fault.
// - monitor faults and auxiliary drive never block general denominator.
// - resume general denominator when criteria-input fault clears.
`timescale 1ns/1ps
`default_nettype none
module monitor_performance_counters #(
   parameter int CNT_W = perf_counter_pkg::CNT_W,
   parameter int MON_PER_COMP = perf_counter_pkg::MON_PER_COMP,
   parameter int TICK_CYCLES = perf_counter_pkg::SEC_CYCLES
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic cycle_start,
   input wire logic engine_running,
   input wire logic veh_speed_ge25,
   input wire logic idle,
   input wire logic elev_below_8k,
   input wire logic ambient_ge20,
   input wire logic criteria_input_fault,
   input wire logic engine_speed_fault,
   input wire logic auxiliary_drive_operation,
   input wire logic [perf_counter_pkg::N_COMP*MON_PER_COMP-1:0] mon_num_inc,
   input wire logic [perf_counter_pkg::N_COMP*MON_PER_COMP-1:0] mon_den_ok,
   input wire logic [perf_counter_pkg::N_COMP*MON_PER_COMP-1:0] mon_disable_fault,
   input wire logic [perf_counter_pkg::N_COMP*MON_PER_COMP-1:0] mon_aux_disable,
   output logic [perf_counter_pkg::N_COMP*CNT_W-1:0] comp_num_q,
   output logic [perf_counter_pkg::N_COMP*CNT_W-1:0] comp_den_q,
   output logic [CNT_W-1:0] gen_den_q,
   output logic [CNT_W-1:0] ign_cnt_q
);
   localparam int NC = perf_counter_pkg::N_COMP;
   localparam int NM = NC * MON_PER_COMP;
   localparam int SW = perf_counter_pkg::SEC_W;
   localparam logic [CNT_W-1:0] CNT_MAX = '1;
   localparam logic [SW-1:0] RUN_LIM = SW'(perf_counter_pkg::RUN_S);
   localparam logic [SW-1:0] SPEED_LIM = SW'(perf_counter_pkg::SPEED_S);
   localparam logic [SW-1:0] IDLE_LIM = SW'(perf_counter_pkg::IDLE_S);
   localparam logic [SW-1:0] IGN_LIM = SW'(perf_counter_pkg::IGN_RUN_S);
   localparam logic [perf_counter_pkg::TICK_W-1:0] TICK_LAST =
      perf_counter_pkg::TICK_W'(TICK_CYCLES - 1);

   // lower ratio wins, larger denominator breaks a tie
   function automatic logic better(input logic [CNT_W-1:0] n, input logic [CNT_W-1:0] d,
                                   input logic [CNT_W-1:0] bn, input logic [CNT_W-1:0] bd);
      logic [2*CNT_W-1:0] l;
      logic [2*CNT_W-1:0] r;
      l = (2*CNT_W)'(n) * (2*CNT_W)'(bd);
      r = (2*CNT_W)'(bn) * (2*CNT_W)'(d);
      return (l < r) || ((l == r) && (d > bd));
   endfunction

   // =====================================================
   // one second time base
   logic [perf_counter_pkg::TICK_W-1:0] tick_q;
   wire sec_tick = (tick_q == TICK_LAST);
   always_ff @(posedge mclk) begin
      if (!resetn) tick_q <= '0;
      else if (ce) tick_q <= sec_tick ? '0 : tick_q + 1'b1;
   end

   // =====================================================
   // base operation criteria timers
   logic [SW-1:0] run_s_q;
   logic [SW-1:0] speed_s_q;
   logic [SW-1:0] idle_s_q;
   logic idle_met_q;
   wire env_ok = elev_below_8k && ambient_ge20;
   wire run_met = (run_s_q >= RUN_LIM);
   wire speed_met = (speed_s_q >= SPEED_LIM);
   wire base_met = run_met && speed_met && idle_met_q;
   wire run_inc = sec_tick && engine_running && env_ok && !run_met;
   wire speed_inc = sec_tick && veh_speed_ge25 && env_ok && !speed_met;
   wire idle_on = idle && env_ok;
   always_ff @(posedge mclk) begin
      if (!resetn || (ce && cycle_start)) begin
         run_s_q <= perf_counter_pkg::SEC_RESET;
         speed_s_q <= perf_counter_pkg::SEC_RESET;
         idle_s_q <= perf_counter_pkg::SEC_RESET;
         idle_met_q <= 1'b0;
      end else if (ce) begin
         if (run_inc) run_s_q <= run_s_q + 1'b1;
         if (speed_inc) speed_s_q <= speed_s_q + 1'b1;
         if (!idle_on) idle_s_q <= perf_counter_pkg::SEC_RESET;
         else if (sec_tick && !idle_met_q) idle_s_q <= idle_s_q + 1'b1;
         if (idle_on && idle_s_q >= IDLE_LIM) idle_met_q <= 1'b1;
      end
   end

   // =====================================================
   // general denominator
   logic gd_done_q;
   wire gd_step = base_met && !gd_done_q && !criteria_input_fault;
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         gen_den_q <= perf_counter_pkg::CNT_RESET;
         gd_done_q <= 1'b0;
      end else if (ce) begin
         if (cycle_start) gd_done_q <= 1'b0;
         else if (gd_step) gd_done_q <= 1'b1;
         if (gd_step && !cycle_start && gen_den_q != CNT_MAX) gen_den_q <= gen_den_q + 1'b1;
      end
   end

   // =====================================================
   // ignition cycle counter
   perf_counter_pkg::ign_state_t ign_st_q;
   perf_counter_pkg::ign_state_t ign_st_d;
   logic [SW-1:0] ign_sec_q;
   wire ign_held = (ign_st_q == perf_counter_pkg::IGN_RUN) && engine_running &&
                   (ign_sec_q >= IGN_LIM);
   wire ign_step = ign_held && !engine_speed_fault && !cycle_start;
   always_comb begin
      ign_st_d = ign_st_q;
      case (ign_st_q)
         perf_counter_pkg::IGN_WAIT: begin
            if (engine_running) ign_st_d = perf_counter_pkg::IGN_RUN;
         end
         perf_counter_pkg::IGN_RUN: begin
            if (!engine_running) ign_st_d = perf_counter_pkg::IGN_WAIT;
            else if (ign_step) ign_st_d = perf_counter_pkg::IGN_DONE;
         end
         perf_counter_pkg::IGN_DONE: ign_st_d = perf_counter_pkg::IGN_DONE;
         default: ign_st_d = perf_counter_pkg::IGN_WAIT;
      endcase
      if (cycle_start) ign_st_d = perf_counter_pkg::IGN_WAIT;
   end
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         ign_st_q <= perf_counter_pkg::IGN_WAIT;
         ign_sec_q <= perf_counter_pkg::SEC_RESET;
         ign_cnt_q <= perf_counter_pkg::CNT_RESET;
      end else if (ce) begin
         ign_st_q <= ign_st_d;
         if (ign_st_d != perf_counter_pkg::IGN_RUN) ign_sec_q <= perf_counter_pkg::SEC_RESET;
         else if (sec_tick && !ign_held) ign_sec_q <= ign_sec_q + 1'b1;
         if (ign_step && ign_cnt_q != CNT_MAX) ign_cnt_q <= ign_cnt_q + 1'b1;
      end
   end

   // =====================================================
   // per-monitor numerators and denominators
   logic [CNT_W-1:0] mon_num_q [NM];
   logic [CNT_W-1:0] mon_den_q [NM];
   logic den_done_q [NM];
   logic [NM-1:0] mon_block;
   logic [CNT_W-1:0] best_n [NM];
   logic [CNT_W-1:0] best_d [NM];

   for (genvar i = 0; i < NM; i++) begin : g_mon
      assign mon_block[i] = mon_disable_fault[i] || criteria_input_fault ||
                            (auxiliary_drive_operation && mon_aux_disable[i]);
      wire num_step = mon_num_inc[i] && !mon_block[i] && mon_num_q[i] != CNT_MAX;
      wire den_step = base_met && mon_den_ok[i] && !den_done_q[i] && !mon_block[i] &&
                      !cycle_start;
      always_ff @(posedge mclk) begin
         if (!resetn) begin
            mon_num_q[i] <= perf_counter_pkg::CNT_RESET;
            mon_den_q[i] <= perf_counter_pkg::CNT_RESET;
            den_done_q[i] <= 1'b0;
         end else if (ce) begin
            if (num_step) mon_num_q[i] <= mon_num_q[i] + 1'b1;
            if (den_step && mon_den_q[i] != CNT_MAX) mon_den_q[i] <= mon_den_q[i] + 1'b1;
            if (cycle_start) den_done_q[i] <= 1'b0;
            else if (den_step) den_done_q[i] <= 1'b1;
         end
      end
      // selection chain within a component
      if (i % MON_PER_COMP == 0) begin : g_first
         assign best_n[i] = mon_num_q[i];
         assign best_d[i] = mon_den_q[i];
      end else begin : g_next
         wire win = better(mon_num_q[i], mon_den_q[i], best_n[i-1], best_d[i-1]);
         assign best_n[i] = win ? mon_num_q[i] : best_n[i-1];
         assign best_d[i] = win ? mon_den_q[i] : best_d[i-1];
      end
   end

   // =====================================================
   // per-component report registers
   for (genvar c = 0; c < NC; c++) begin : g_comp
      localparam int LAST = c * MON_PER_COMP + MON_PER_COMP - 1;
      always_ff @(posedge mclk) begin
         if (!resetn) begin
            comp_num_q[c*CNT_W +: CNT_W] <= perf_counter_pkg::CNT_RESET;
            comp_den_q[c*CNT_W +: CNT_W] <= perf_counter_pkg::CNT_RESET;
         end else if (ce) begin
            comp_num_q[c*CNT_W +: CNT_W] <= best_n[LAST];
            comp_den_q[c*CNT_W +: CNT_W] <= best_d[LAST];
         end
      end
   end

   // =====================================================
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   AST_MON_FAULT_HOLD: assert property (
      (ce && mon_disable_fault[0]) |=> (mon_num_q[0] == $past(mon_num_q[0])) &&
                                       (mon_den_q[0] == $past(mon_den_q[0])))
      else $error("disabled monitor count moved");
   AST_MON_RESUME: assert property (
      (ce && mon_num_inc[0] && !mon_block[0] && mon_num_q[0] != CNT_MAX)
      |=> mon_num_q[0] == $past(mon_num_q[0]) + 1'b1)
      else $error("monitor numerator did not resume");
   AST_AUX_HOLD: assert property (
      (ce && auxiliary_drive_operation && mon_aux_disable[0]) |=> $stable(mon_den_q[0]))
      else $error("denominator moved under auxiliary drive");
   AST_AUX_END: assert property (
      (ce && !auxiliary_drive_operation && !mon_disable_fault[0] && !criteria_input_fault &&
       mon_num_inc[0] && mon_num_q[0] != CNT_MAX) |=> $changed(mon_num_q[0]))
      else $error("counts not resumed after auxiliary drive");
   AST_CRIT_FREEZE: assert property (
      (ce && criteria_input_fault) |=> $stable(mon_num_q[NM-1]) && $stable(mon_den_q[NM-1])
                                       && $stable(gen_den_q))
      else $error("count moved under criteria fault");
   AST_REPORT_BEST: assert property (
      ce |=> comp_num_q[CNT_W-1:0] == $past(best_n[MON_PER_COMP-1]))
      else $error("reported pair is not the selected monitor");
   AST_IGN_STEP_ONE: assert property (
      $changed(ign_cnt_q) |-> ign_cnt_q == $past(ign_cnt_q) + 1'b1)
      else $error("ignition counter stepped by other than one");
   AST_IGN_ONCE: assert property (
      (ign_st_q == perf_counter_pkg::IGN_DONE && !cycle_start) |=> $stable(ign_cnt_q))
      else $error("ignition counter stepped twice in a cycle");
   AST_IGN_TIME: assert property (
      $changed(ign_cnt_q) |-> $past(engine_running) && $past(ign_sec_q) >= IGN_LIM)
      else $error("ignition counter stepped too early");
   AST_IGN_FAULT: assert property (
      (ce && engine_speed_fault) |=> $stable(ign_cnt_q))
      else $error("ignition counter stepped under fault");
   AST_GD_CRITERIA: assert property (
      $changed(gen_den_q) |-> $past(base_met) && !$past(gd_done_q))
      else $error("general denominator stepped without criteria");
   AST_GD_NOT_BLOCKED: assert property (
      (ce && (auxiliary_drive_operation || (|mon_disable_fault)) && base_met && !gd_done_q &&
       !criteria_input_fault && !cycle_start && gen_den_q != CNT_MAX)
      |=> (gen_den_q == $past(gen_den_q) + 1'b1) && gd_done_q)
      else $error("general denominator blocked");
   AST_GD_FAULT: assert property (
      (ce && criteria_input_fault) |=> $stable(gen_den_q))
      else $error("general denominator stepped under criteria fault");
   AST_GD_RESUME: assert property (
      (ce && $past(criteria_input_fault) && !criteria_input_fault && base_met && !gd_done_q &&
       !cycle_start && gen_den_q != CNT_MAX) |=> gen_den_q == $past(gen_den_q) + 1'b1)
      else $error("general denominator did not resume");
   AST_GD_STEP_ONE: assert property (
      $changed(gen_den_q) |-> gen_den_q == $past(gen_den_q) + 1'b1)
      else $error("general denominator stepped by other than one");
   AST_GD_ONCE: assert property (
      (gd_done_q && !cycle_start) |=> $stable(gen_den_q))
      else $error("general denominator stepped twice in a cycle");
   AST_IDLE_TIME: assert property (
      $rose(idle_met_q) |-> $past(idle_s_q) >= IDLE_LIM)
      else $error("idle criterion met too early");
   AST_RUN_TIME: assert property (
      $rose(run_met) |-> $past(run_inc))
      else $error("run time criterion met without a counted second");
   AST_IGN_RESUME: assert property (
      (ce && ign_st_q == perf_counter_pkg::IGN_RUN && engine_running && ign_sec_q >= IGN_LIM &&
       !engine_speed_fault && !cycle_start && ign_cnt_q != CNT_MAX)
      |=> ign_cnt_q == $past(ign_cnt_q) + 1'b1)
      else $error("ignition counter did not step");
   AST_IGN_EARLY: assert property (
      (ign_st_q != perf_counter_pkg::IGN_RUN) |=> $stable(ign_cnt_q))
      else $error("ignition counter stepped outside the run state");
   AST_AUX_NUM: assert property (
      (ce && auxiliary_drive_operation && mon_aux_disable[0]) |=> $stable(mon_num_q[0]))
      else $error("numerator moved under auxiliary drive");
   AST_CRIT_RESUME: assert property (
      (ce && $past(criteria_input_fault) && !criteria_input_fault && base_met &&
       mon_den_ok[0] && !den_done_q[0] && !mon_disable_fault[0] && !cycle_start &&
       !(auxiliary_drive_operation && mon_aux_disable[0]) && mon_den_q[0] != CNT_MAX)
      |=> mon_den_q[0] == $past(mon_den_q[0]) + 1'b1)
      else $error("monitor denominator did not restart");
   AST_REPORT_DEN: assert property (
      ce |=> comp_den_q[NC*CNT_W-1 -: CNT_W] == $past(best_d[NM-1]))
      else $error("reported denominator is not the selected monitor");
   AST_LOW_RATIO: assert property (
      (ce && MON_PER_COMP == 2 &&
       (2*CNT_W)'(mon_num_q[1]) * mon_den_q[0] < (2*CNT_W)'(mon_num_q[0]) * mon_den_q[1])
      |=> (comp_num_q[CNT_W-1:0] == $past(mon_num_q[1])) &&
          (comp_den_q[CNT_W-1:0] == $past(mon_den_q[1])))
      else $error("component did not report its lowest ratio");
   AST_TIE_DEN: assert property (
      (ce && MON_PER_COMP == 2 && mon_den_q[5] > mon_den_q[4] &&
       (2*CNT_W)'(mon_num_q[5]) * mon_den_q[4] == (2*CNT_W)'(mon_num_q[4]) * mon_den_q[5])
      |=> comp_den_q[3*CNT_W-1 -: CNT_W] == $past(mon_den_q[5]))
      else $error("tie not broken by the larger denominator");
endmodule
`default_nettype wire

//--- hw/perf_counter_pkg.sv
package perf_counter_pkg;
   // =====================================================
   // clock and time base
   localparam int CLK_PERIOD_NS = 5;
   localparam int SEC_NS = 1000000000;
   localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
   localparam int TICK_W = 28;
   // =====================================================
   // response and criteria times, seconds
   localparam int RESP_S = 10;
   localparam int IGN_RUN_S = 2;
   localparam int RUN_S = 600;
   localparam int SPEED_S = 300;
   localparam int IDLE_S = 30;
   localparam int SEC_W = 10;
   // =====================================================
   // components and counters
   localparam int N_COMP = 7;
   localparam int MON_PER_COMP = 2;
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
   localparam logic [SEC_W-1:0] SEC_RESET = 10'h000;
   typedef enum logic [1:0] {
      IGN_WAIT = 2'h0,
      IGN_RUN = 2'h1,
      IGN_DONE = 2'h3
   } ign_state_t;
endpackage

//--- tb/scan_tool_model.sv
`timescale 1ns/1ps
`default_nettype none
module scan_tool_model #(
   parameter int CNT_W = 16
) (
   input wire logic mclk,
   input wire logic [2:0] sel,
   input wire logic [perf_counter_pkg::N_COMP*CNT_W-1:0] comp_num,
   input wire logic [perf_counter_pkg::N_COMP*CNT_W-1:0] comp_den,
   output logic [CNT_W-1:0] num,
   output logic [CNT_W-1:0] den
);
   // =====================================================
   // snapshot of one reported pair per request
   always_ff @(posedge mclk) begin
      num <= comp_num[sel*CNT_W +: CNT_W];
      den <= comp_den[sel*CNT_W +: CNT_W];
   end
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) begin \
         fail_count++; \
         $display("wrong value %s expected %0h seen %0h", what, exp, got); \
      end \
   end
module tb;
   localparam int TK = 4;
   localparam int W = perf_counter_pkg::CNT_W;
   localparam int NM = perf_counter_pkg::N_COMP * perf_counter_pkg::MON_PER_COMP;
   logic mclk = 1'b0;
   logic resetn, ce, cyc_start, running, spd, idle, elev, amb, cif, esf, aux;
   logic [NM-1:0] num_inc, den_ok, dis_f, aux_dis;
   logic [perf_counter_pkg::N_COMP*W-1:0] comp_num, comp_den;
   logic [W-1:0] gen_den, ign_cnt, rd_num, rd_den;
   logic [2:0] sel;
   int fail_count = 0;
   int n_compared = 0;
   monitor_performance_counters #(.TICK_CYCLES(TK)) i_monitor_performance_counters (
      .mclk(mclk), .resetn(resetn), .ce(ce), .cycle_start(cyc_start),
      .engine_running(running), .veh_speed_ge25(spd), .idle(idle),
      .elev_below_8k(elev), .ambient_ge20(amb), .criteria_input_fault(cif),
      .engine_speed_fault(esf), .auxiliary_drive_operation(aux),
      .mon_num_inc(num_inc), .mon_den_ok(den_ok), .mon_disable_fault(dis_f),
      .mon_aux_disable(aux_dis), .comp_num_q(comp_num), .comp_den_q(comp_den),
      .gen_den_q(gen_den), .ign_cnt_q(ign_cnt));
   scan_tool_model #(.CNT_W(W)) i_scan_tool_model (
      .mclk(mclk), .sel(sel), .comp_num(comp_num), .comp_den(comp_den),
      .num(rd_num), .den(rd_den));
   initial begin
      forever #2.5 mclk = ~mclk;
   end
   // =====================================================
   // access tasks
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic new_cycle;
      cyc_start = 1'b1;
      cyc(1);
      cyc_start = 1'b0;
   endtask
   task automatic pulse_num(input int i);
      num_inc[i] = 1'b1;
      cyc(1);
      num_inc[i] = 1'b0;
      cyc(2);
   endtask
   task automatic chk_comp(input logic [2:0] c, input logic [W-1:0] en, input logic [W-1:0] ed);
      sel = c;
      cyc(1);
      `CHECK("comp num", en, rd_num)
      `CHECK("comp den", ed, rd_den)
   endtask
   task automatic wait_eq(input bit g, input logic [W-1:0] exp, input int lim);
      int k;
      k = 0;
      while ((g ? gen_den : ign_cnt) !== exp && k < lim) begin
         cyc(1);
         k++;
      end
      `CHECK(g ? "general den" : "ignition count", exp, (g ? gen_den : ign_cnt))
      if (k >= lim && (g ? gen_den : ign_cnt) !== exp) begin
         finish_test;
      end
   endtask
   // =====================================================
   // scenarios
   initial begin
      {resetn, cyc_start, running, spd, idle, cif, esf, aux} = 8'h00;
      {ce, elev, amb} = 3'h7;
      num_inc = '0;
      den_ok = '1;
      dis_f = '0;
      aux_dis = '0;
      sel = 3'h0;
      cyc(8);
      resetn = 1'b1;
      `CHECK("general den", 16'h0000, gen_den)
      chk_comp(3'h6, 16'h0000, 16'h0000);
      new_cycle;
      running = 1'b1;
      wait_eq(1'b0, 16'h0001, 3 * TK + 4);
      cyc(3 * TK);
      `CHECK("ignition count", 16'h0001, ign_cnt)
      pulse_num(0);
      chk_comp(3'h0, 16'h0001, 16'h0000);
      dis_f[0] = 1'b1;
      pulse_num(0);
      dis_f[0] = 1'b0;
      chk_comp(3'h0, 16'h0001, 16'h0000);
      pulse_num(0);
      chk_comp(3'h0, 16'h0002, 16'h0000);
      aux = 1'b1;
      aux_dis[0] = 1'b1;
      pulse_num(0);
      chk_comp(3'h0, 16'h0002, 16'h0000);
      aux = 1'b0;
      pulse_num(0);
      chk_comp(3'h0, 16'h0003, 16'h0000);
      cif = 1'b1;
      pulse_num(0);
      cif = 1'b0;
      chk_comp(3'h0, 16'h0003, 16'h0000);
      pulse_num(0);
      chk_comp(3'h0, 16'h0004, 16'h0000);
      ce = 1'b0;
      pulse_num(0);
      ce = 1'b1;
      chk_comp(3'h0, 16'h0004, 16'h0000);
      aux_dis = '0;
      idle = 1'b1;
      cyc(35 * TK);
      idle = 1'b0;
      spd = 1'b1;
      dis_f[4] = 1'b1;
      aux_dis[12] = 1'b1;
      aux = 1'b1;
      cyc(550 * TK);
      wait_eq(1'b1, 16'h0001, 100 * TK);
      cyc(3);
      chk_comp(3'h0, 16'h0000, 16'h0001);
      chk_comp(3'h2, 16'h0000, 16'h0001);
      cyc(10 * TK);
      `CHECK("general den", 16'h0001, gen_den)
      dis_f = '0;
      aux_dis = '0;
      aux = 1'b0;
      new_cycle;
      esf = 1'b1;
      cyc(5 * TK);
      `CHECK("ignition count", 16'h0001, ign_cnt)
      esf = 1'b0;
      wait_eq(1'b0, 16'h0002, 3 * TK + 4);
      {idle, spd} = 2'h2;
      cyc(35 * TK);
      {idle, spd} = 2'h1;
      cif = 1'b1;
      cyc(640 * TK);
      `CHECK("general den", 16'h0001, gen_den)
      chk_comp(3'h0, 16'h0000, 16'h0001);
      cif = 1'b0;
      wait_eq(1'b1, 16'h0002, 700 * TK);
      cyc(3);
      chk_comp(3'h0, 16'h0000, 16'h0002);
      finish_test;
   end
endmodule
`default_nettype wire
